// ### rtl/slk_suspend_lock.sv
// Serial command handling for erase-suspend programming, resume and
// individual block locking inside a serial NOR flash.
// Assumes cs_n, sclk and io_in synchronous to a much faster sys_clk; the
// array engine and suspend decode talk through op_cmd, op_done, suspend_req.
// What this block does
// - In erase suspend, program unprotected units outside the suspended unit.
// - A program nested in erase suspend cannot suspend; resume is refused until it ends.
// - Nested program holds write latch and in-progress at 1, clears on finish.
// - Erase suspend shows in status bit 15, program suspend in bit 10.
// - Resume restarts the suspended program or erase.
// - On resume set write latch and in-progress, clear the suspend flag.
// - After resume the operation runs until done or suspended again.
// - No-operation only cancels a pending reset arm.
// - Lock bits protect only when scheme select is 1, else range bits.
// - Lock bits are volatile and all 1 after reset.
// - Lock command 36h plus 3-byte address locks one block or sector.
// - Lock and unlock commands execute only after write enable.
// - Lock and unlock execute only if select rises on a byte boundary.
// - Unlock command 39h plus 3-byte address unlocks one block or sector.
// - Lock read 3Dh plus address returns the lock bit in first byte.
// - Lock status 1 means read only, 0 means writable.
// - Lock read and global commands accepted in single and quad form.
// - Opcode 7Eh alone sets every lock bit.
// - Opcode 98h alone clears every lock bit.
// - Suspend flag is 1 while suspended, 0 once resumed.
`timescale 1ns/1ns
`default_nettype none
module slk_suspend_lock #(
   parameter int BLOCKS = 64
) (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire logic               cs_n,
   input  wire logic               sclk,
   input  wire logic [3:0]         io_in,
   output logic [3:0]              io_out,
   output logic [3:0]              io_oe,
   input  wire logic               qpi_mode,
   input  wire logic               protect_scheme_select,
   input  wire logic               bp_region_protected,
   input  wire logic               suspend_req,
   input  wire logic               op_done,
   output slk_pkg::slk_op_type     op_cmd,
   output logic                    write_latch_flag,
   output logic                    in_progress_flag,
   output logic                    erase_suspended_flag,
   output logic                    program_suspended_flag,
   output logic                    suspended_flag,
   output logic                    reset_armed,
   output logic [15:0]             status_word
);
   localparam int AW = slk_pkg::ADDR_W;
   logic                    sclk_d_r, cs_n_d_r;
   logic [7:0]              shift_r;
   logic [7:0]              shift_nxt;
   logic [2:0]              bit_cnt_r;
   logic [2:0]              bit_nxt;
   logic [2:0]              byte_cnt_r;
   logic [7:0]              opcode_r;
   logic [AW-1:0]           addr_r;
   logic [7:0]              out_sh_r;
   logic [7:0]              out_sh_nxt;
   logic [3:0]              io_out_r;
   logic [3:0]              io_oe_r;
   slk_pkg::slk_state_type  state_r;
   slk_pkg::slk_kind_type   cur_kind_r;
   logic [AW-1:0]           cur_addr_r;
   slk_pkg::slk_kind_type   sus_kind_r;
   logic [AW-1:0]           sus_addr_r;
   slk_pkg::slk_op_type     op_r;
   logic                    wel_r, wip_r, esus_r, psus_r, sus_r, arm_r;
   logic                    unit_locked;
   function automatic logic same_unit(
      input slk_pkg::slk_kind_type k,
      input logic [AW-1:0]         a,
      input logic [AW-1:0]         b);
      if (k == slk_pkg::OPK_BLOCK) begin
         return a[AW-1:slk_pkg::BLOCK_LSB] == b[AW-1:slk_pkg::BLOCK_LSB];
      end
      return a[AW-1:slk_pkg::SECTOR_LSB] == b[AW-1:slk_pkg::SECTOR_LSB];
   endfunction
   // Only program or erase opcodes reach this decode
   function automatic slk_pkg::slk_kind_type kind_of(input logic [7:0] op);
      case (op)
         slk_pkg::OP_BLOCK_ERASE:  return slk_pkg::OPK_BLOCK;
         slk_pkg::OP_SECTOR_ERASE: return slk_pkg::OPK_SECTOR;
         default:                  return slk_pkg::OPK_PROG;
      endcase
   endfunction
   wire sclk_rise = !cs_n && sclk && !sclk_d_r;
   wire sclk_fall = !cs_n && !sclk && sclk_d_r;
   wire cs_rise   = cs_n && !cs_n_d_r;
   wire [2:0] step = qpi_mode ? slk_pkg::QPI_STEP : slk_pkg::SPI_STEP;
   wire byte_done = sclk_rise && (bit_nxt == 3'h0);
   assign bit_nxt = bit_cnt_r + step;
   // Quad takes a nibble per rise, single line only io_in[0]
   assign shift_nxt = qpi_mode ? {shift_r[3:0], io_in}
                               : {shift_r[6:0], io_in[0]};
   // Command decode at the rising edge of chip select
   wire aligned   = (bit_cnt_r == 3'h0);
   wire one_byte  = aligned && (byte_cnt_r == slk_pkg::CMD_ONE_BYTE);
   wire addr_only = aligned && (byte_cnt_r == slk_pkg::CMD_ADDR_LEN);
   wire with_data = aligned && (byte_cnt_r > slk_pkg::CMD_ADDR_LEN);
   wire is_prog   = (opcode_r == slk_pkg::OP_PAGE_PROG) ||
                    (opcode_r == slk_pkg::OP_QUAD_PROG);
   wire is_erase  = (opcode_r == slk_pkg::OP_SECTOR_ERASE) ||
                    (opcode_r == slk_pkg::OP_BLOCK_ERASE);
   wire ready     = (state_r == slk_pkg::ST_IDLE) ||
                    (state_r == slk_pkg::ST_SUSP);
   wire cmd1      = cs_rise && one_byte;
   wire cmd4      = cs_rise && addr_only;
   wire exec_write_enable_cmd = cmd1 && (opcode_r == slk_pkg::OP_WRITE_ENABLE);
   wire exec_res  = cmd1 && (opcode_r == slk_pkg::OP_RESUME);
   wire exec_glk  = cmd1 && (opcode_r == slk_pkg::OP_GLOBAL_LOCK);
   wire exec_gulk = cmd1 && (opcode_r == slk_pkg::OP_GLOBAL_UNLOCK);
   wire exec_lk   = cmd4 && (opcode_r == slk_pkg::OP_SINGLE_LOCK);
   wire exec_ulk  = cmd4 && (opcode_r == slk_pkg::OP_SINGLE_UNLOCK);
   wire exec_prog = cs_rise && with_data && is_prog;
   wire exec_ers  = cmd4 && is_erase;
   wire any_cmd   = cs_rise && (byte_cnt_r != 3'h0);
   wire lock_ok   = ready && wel_r;
   wire protected_unit = protect_scheme_select ?
                         unit_locked : bp_region_protected;
   wire start_ok  = (state_r == slk_pkg::ST_IDLE) && wel_r &&
                    !protected_unit && (exec_prog || exec_ers);
   wire nest_ok   = (state_r == slk_pkg::ST_SUSP) && esus_r && wel_r &&
                    exec_prog && !protected_unit &&
                    !same_unit(sus_kind_r, sus_addr_r, addr_r);
   // A nested program blocks resume until it completes
   wire resume_ok = (state_r == slk_pkg::ST_SUSP) && exec_res;
   wire busy_end  = ((state_r == slk_pkg::ST_BUSY) ||
                     (state_r == slk_pkg::ST_NEST)) && op_done;
   // Nested program ignores suspend requests
   wire do_susp   = (state_r == slk_pkg::ST_BUSY) && suspend_req &&
                    !op_done;
   wire consume   = ready && wel_r && (exec_prog || exec_ers || exec_lk ||
                    exec_ulk || exec_glk || exec_gulk);
   slk_lock_bits #(
      .BLOCKS (BLOCKS)
   ) u_lock_bits (
      .sys_clk     (sys_clk),
      .rstn        (rstn),
      .lock_one    (exec_lk && lock_ok),
      .unlock_one  (exec_ulk && lock_ok),
      .lock_all    (exec_glk && lock_ok),
      .unlock_all  (exec_gulk && lock_ok),
      .unit_addr   (addr_r),
      .unit_locked (unit_locked)
   );
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk;
         cs_n_d_r <= cs_n;
      end
   end
   // Deserialiser: opcode byte, then three address bytes
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         shift_r    <= 8'h00;
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 3'h0;
         opcode_r   <= 8'h00;
         addr_r     <= '0;
      end else if (cs_n) begin
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 3'h0;
      end else if (sclk_rise) begin
         shift_r   <= shift_nxt;
         bit_cnt_r <= bit_nxt;
         if (byte_done) begin
            if (byte_cnt_r != slk_pkg::BYTE_CNT_MAX) begin
               byte_cnt_r <= byte_cnt_r + 3'h1;
            end
            if (byte_cnt_r == 3'h0) begin
               opcode_r <= shift_nxt;
            end else if (byte_cnt_r < slk_pkg::CMD_ADDR_LEN) begin
               addr_r <= {addr_r[AW-9:0], shift_nxt};
            end
         end
      end
   end
   // Lock status byte out on falling edges, repeated per byte
   assign out_sh_nxt = (bit_cnt_r == 3'h0) ? {7'h00, unit_locked}
                     : qpi_mode ? {out_sh_r[3:0], 4'h0}
                     : {out_sh_r[6:0], 1'b0};
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         out_sh_r <= 8'h00;
         io_out_r <= 4'h0;
         io_oe_r  <= 4'h0;
      end else if (cs_n) begin
         io_out_r <= 4'h0;
         io_oe_r  <= 4'h0;
      end else if (sclk_fall && ready &&
                   (opcode_r == slk_pkg::OP_LOCK_STATUS_READ) &&
                   (byte_cnt_r >= slk_pkg::CMD_ADDR_LEN)) begin
         out_sh_r <= out_sh_nxt;
         io_out_r <= qpi_mode ? out_sh_nxt[7:4]
                              : {2'b00, out_sh_nxt[7], 1'b0};
         io_oe_r  <= qpi_mode ? slk_pkg::QPI_OE : slk_pkg::SPI_OE;
      end
   end
   // Operation sequencing and the suspended program or erase context
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_r    <= slk_pkg::ST_IDLE;
         cur_kind_r <= slk_pkg::OPK_PROG;
         cur_addr_r <= '0;
         sus_kind_r <= slk_pkg::OPK_PROG;
         sus_addr_r <= '0;
      end else begin
         case (state_r)
            slk_pkg::ST_IDLE: begin
               if (start_ok) begin
                  state_r    <= slk_pkg::ST_BUSY;
                  cur_addr_r <= addr_r;
                  cur_kind_r <= kind_of(opcode_r);
               end
            end
            slk_pkg::ST_BUSY: begin
               if (op_done) begin
                  state_r <= slk_pkg::ST_IDLE;
               end else if (do_susp) begin
                  state_r    <= slk_pkg::ST_SUSP;
                  sus_kind_r <= cur_kind_r;
                  sus_addr_r <= cur_addr_r;
               end
            end
            slk_pkg::ST_SUSP: begin
               if (resume_ok) begin
                  state_r    <= slk_pkg::ST_BUSY;
                  cur_kind_r <= sus_kind_r;
                  cur_addr_r <= sus_addr_r;
               end else if (nest_ok) begin
                  state_r    <= slk_pkg::ST_NEST;
                  cur_kind_r <= slk_pkg::OPK_PROG;
                  cur_addr_r <= addr_r;
               end
            end
            slk_pkg::ST_NEST: begin
               if (op_done) begin
                  state_r    <= slk_pkg::ST_SUSP;
               end
            end
            default: begin
               state_r <= slk_pkg::ST_IDLE;
            end
         endcase
      end
   end
   // Requests to the array engine, one-cycle pulses with the target
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         op_r <= '0;
      end else begin
         op_r.start   <= start_ok || nest_ok;
         op_r.resume  <= resume_ok;
         op_r.suspend <= do_susp;
         if (start_ok || nest_ok) begin
            op_r.addr <= addr_r;
            op_r.kind <= kind_of(opcode_r);
         end else if (resume_ok) begin
            op_r.addr <= sus_addr_r;
            op_r.kind <= sus_kind_r;
         end
      end
   end
   // Write latch: an accepted program or erase keeps it set until done or suspended
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wel_r <= 1'b0;
      end else if (resume_ok) begin
         wel_r <= 1'b1;
      end else if (exec_write_enable_cmd && ready) begin
         wel_r <= 1'b1;
      end else if (busy_end || do_susp) begin
         wel_r <= 1'b0;
      end else if (consume && !start_ok && !nest_ok) begin
         wel_r <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wip_r <= 1'b0;
      end else if (start_ok || nest_ok || resume_ok) begin
         wip_r <= 1'b1;
      end else if (busy_end || do_susp) begin
         wip_r <= 1'b0;
      end
   end
   // Suspend flags; suspend only comes from busy, resume only from suspend
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         esus_r <= 1'b0;
         psus_r <= 1'b0;
         sus_r  <= 1'b0;
      end else if (do_susp) begin
         esus_r <= (cur_kind_r != slk_pkg::OPK_PROG);
         psus_r <= (cur_kind_r == slk_pkg::OPK_PROG);
         sus_r  <= 1'b1;
      end else if (resume_ok) begin
         esus_r <= 1'b0;
         psus_r <= 1'b0;
         sus_r  <= 1'b0;
      end
   end
   // Any other complete command also disarms reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         arm_r <= 1'b0;
      end else if (any_cmd) begin
         arm_r <= one_byte && (opcode_r == slk_pkg::OP_RESET_ARM);
      end
   end
   always_comb begin
      status_word = 16'h0000;
      status_word[slk_pkg::STAT_IN_PROGRESS] = wip_r;
      status_word[slk_pkg::STAT_WRITE_LATCH] = wel_r;
      status_word[slk_pkg::STAT_PROG_SUSP]   = psus_r;
      status_word[slk_pkg::STAT_ERASE_SUSP]  = esus_r;
   end
   assign io_out                 = io_out_r;
   assign io_oe                  = io_oe_r;
   assign op_cmd                 = op_r;
   assign write_latch_flag       = wel_r;
   assign in_progress_flag       = wip_r;
   assign erase_suspended_flag   = esus_r;
   assign program_suspended_flag = psus_r;
   assign suspended_flag         = sus_r;
   assign reset_armed            = arm_r;
endmodule
`default_nettype wire

// ### pkg/slk_pkg.sv
// Constants, opcodes and carrier types for the suspend/resume and lock block.
// Assumes a 24-bit array address and one system clock.
package slk_pkg;

   localparam int ADDR_W = 24;

   localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
   localparam logic [7:0] OP_RESUME           = 8'h7A;
   localparam logic [7:0] OP_PAGE_PROG        = 8'h02;
   localparam logic [7:0] OP_QUAD_PROG        = 8'h32;
   localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE      = 8'hD8;
   localparam logic [7:0] OP_NO_OPERATION     = 8'h00;
   localparam logic [7:0] OP_RESET_ARM        = 8'h66;
   localparam logic [7:0] OP_SINGLE_LOCK      = 8'h36;
   localparam logic [7:0] OP_SINGLE_UNLOCK    = 8'h39;
   localparam logic [7:0] OP_LOCK_STATUS_READ = 8'h3D;
   localparam logic [7:0] OP_GLOBAL_LOCK      = 8'h7E;
   localparam logic [7:0] OP_GLOBAL_UNLOCK    = 8'h98;

   // Opcode byte plus three address bytes
   localparam logic [2:0] CMD_ONE_BYTE  = 3'h1;
   localparam logic [2:0] CMD_ADDR_LEN  = 3'h4;
   localparam logic [2:0] BYTE_CNT_MAX  = 3'h7;
   localparam logic [2:0] SPI_STEP      = 3'h1;
   localparam logic [2:0] QPI_STEP      = 3'h4;
   localparam logic [3:0] SPI_OE        = 4'h2;
   localparam logic [3:0] QPI_OE        = 4'hF;

   localparam int BLOCK_LSB  = 16;
   localparam int SECTOR_LSB = 12;
   localparam int SECTORS_PER_BLOCK = 16;
   localparam logic LOCK_RESET = 1'b1;

   localparam int STAT_IN_PROGRESS = 0;
   localparam int STAT_WRITE_LATCH = 1;
   localparam int STAT_PROG_SUSP   = 10;
   localparam int STAT_ERASE_SUSP  = 15;

   typedef enum logic [1:0] {
      OPK_PROG   = 2'h0,
      OPK_SECTOR = 2'h1,
      OPK_BLOCK  = 2'h2
   } slk_kind_type;

   // Gray codes along idle, busy, suspended, nested program
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_BUSY = 2'h1,
      ST_SUSP = 2'h3,
      ST_NEST = 2'h2
   } slk_state_type;

   typedef struct packed {
      logic              start;
      logic              resume;
      logic              suspend;
      slk_kind_type      kind;
      logic [ADDR_W-1:0] addr;
   } slk_op_type;

endpackage

// ### rtl/slk_lock_bits.sv
// Volatile lock bits: one per 64 KB block, one per 4 KB sector in the
// lowest and highest block. Assumes one clock and a 24-bit address.
`timescale 1ns/1ns
`default_nettype none
module slk_lock_bits #(
   parameter int BLOCKS = 64
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rstn,
   input  wire logic                        lock_one,
   input  wire logic                        unlock_one,
   input  wire logic                        lock_all,
   input  wire logic                        unlock_all,
   input  wire logic [slk_pkg::ADDR_W-1:0]  unit_addr,
   output logic                             unit_locked
);
   localparam int BLK_W = $clog2(BLOCKS);
   localparam int SEC_W = $clog2(slk_pkg::SECTORS_PER_BLOCK);
   localparam int SEC_N = 2 * slk_pkg::SECTORS_PER_BLOCK;

   if (BLOCKS < 2 || (1 << BLK_W) != BLOCKS ||
       BLK_W + slk_pkg::BLOCK_LSB > slk_pkg::ADDR_W) begin : g_bad
      $error("BLOCKS must be a power of two that fits the address");
   end

   logic [BLOCKS-1:0] blk_r;
   logic [SEC_N-1:0]  sec_r;

   function automatic logic [BLK_W-1:0] blk_of(
      input logic [slk_pkg::ADDR_W-1:0] a);
      return a[slk_pkg::BLOCK_LSB +: BLK_W];
   endfunction

   // Only the two end blocks are split into sectors
   function automatic logic in_sector_zone(
      input logic [slk_pkg::ADDR_W-1:0] a);
      return (blk_of(a) == '0) || (blk_of(a) == '1);
   endfunction

   function automatic logic [SEC_W:0] sec_of(
      input logic [slk_pkg::ADDR_W-1:0] a);
      return {blk_of(a) == '1, a[slk_pkg::SECTOR_LSB +: SEC_W]};
   endfunction

   always_comb begin
      if (in_sector_zone(unit_addr)) begin
         unit_locked = sec_r[sec_of(unit_addr)];
      end else begin
         unit_locked = blk_r[blk_of(unit_addr)];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         blk_r <= {BLOCKS{slk_pkg::LOCK_RESET}};
         sec_r <= {SEC_N{slk_pkg::LOCK_RESET}};
      end else if (lock_all) begin
         blk_r <= '1;
         sec_r <= '1;
      end else if (unlock_all) begin
         blk_r <= '0;
         sec_r <= '0;
      end else if (lock_one || unlock_one) begin
         if (in_sector_zone(unit_addr)) begin
            sec_r[sec_of(unit_addr)] <= lock_one;
         end else begin
            blk_r[blk_of(unit_addr)] <= lock_one;
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/slk_checker.sv
// Port checker for the suspend/resume and lock command block.
// Bound into slk_suspend_lock; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module slk_checker (
   input wire logic                sys_clk,
   input wire logic                rstn,
   input wire logic                cs_n,
   input wire logic [3:0]          io_oe,
   input wire logic                op_done,
   input wire slk_pkg::slk_op_type op_cmd,
   input wire logic                write_latch_flag,
   input wire logic                in_progress_flag,
   input wire logic                erase_suspended_flag,
   input wire logic                program_suspended_flag,
   input wire logic                suspended_flag,
   input wire logic [15:0]         status_word
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic nest;
   // Program nested inside a suspended erase
   assign nest = erase_suspended_flag && in_progress_flag;
   status_map_a: assert property (
      status_word == {erase_suspended_flag, 4'h0, program_suspended_flag,
      8'h00, write_latch_flag, in_progress_flag})
      else $error("status word out of step with flags");
   susp_any_a: assert property (
      erase_suspended_flag || program_suspended_flag |-> suspended_flag)
      else $error("suspend flag low while suspended");
   resume_flags_a: assert property (
      op_cmd.resume |-> write_latch_flag && in_progress_flag && !suspended_flag)
      else $error("flags wrong on resume");
   resume_pulse_a: assert property (
      op_cmd.resume |=> !op_cmd.resume)
      else $error("resume pulse too long");
   susp_fall_a: assert property (
      $fell(suspended_flag) |-> op_cmd.resume)
      else $error("suspend cleared without resume");
   nest_latch_a: assert property (
      nest |-> write_latch_flag)
      else $error("latch low during nested program");
   nest_done_a: assert property (
      nest && op_done |=> !in_progress_flag && !write_latch_flag)
      else $error("flags not cleared after nested program");
   nest_nosusp_a: assert property (
      nest |-> !op_cmd.suspend)
      else $error("nested program suspended");
   start_latch_a: assert property (
      op_cmd.start |-> $past(write_latch_flag))
      else $error("operation started without write latch");
   oe_idle_a: assert property (
      $past(cs_n, 2) && $past(cs_n) && cs_n |-> io_oe == 4'h0)
      else $error("output enabled while deselected");
   cover property (op_cmd.resume);
   cover property (nest && op_done);
   cover property (erase_suspended_flag && !in_progress_flag);
endmodule
bind slk_suspend_lock slk_checker i_chk (.sys_clk, .rstn, .cs_n, .io_oe,
   .op_done, .op_cmd, .write_latch_flag, .in_progress_flag,
   .erase_suspended_flag, .program_suspended_flag, .suspended_flag,
   .status_word);
`default_nettype wire

// ### verification/slk_host_model.sv
// Host controller model: frames commands on cs_n, sclk and io_in.
// Called by the bench; sclk stands still and data lines toggle between frames.
`timescale 1ns/1ns
`default_nettype none
module slk_host_model #(
   parameter int HALF = 3
) (
   input  wire logic       sys_clk,
   input  wire logic       qpi_mode,
   input  wire logic [3:0] io_out,
   output logic            cs_n,
   output logic            sclk,
   output logic [3:0]      io_in,
   output logic [7:0]      rd_byte
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      io_in = 4'h0;
      rd_byte = 8'h00;
   end
   // MSB first, address A23 down; xb adds stray beats
   task automatic frame(input logic [39:0] d, input int nb, input int xb);
      logic [39:0] sh;
      int          st;
      int          i;
      sh = d;
      st = qpi_mode ? 4 : 1;
      @(posedge sys_clk) #1 cs_n = 1'b0;
      for (i = 0; i < nb * 8 + xb * st; i += st) begin
         io_in = qpi_mode ? sh[39:36] : {~io_in[3:1], sh[39]};
         sh = sh << st;
         repeat (HALF) @(posedge sys_clk);
         #1 sclk = 1'b1;
         rd_byte = qpi_mode ? {rd_byte[3:0], io_out}
                            : {rd_byte[6:0], io_out[1]};
         repeat (HALF) @(posedge sys_clk);
         #1 sclk = 1'b0;
      end
      repeat (HALF) @(posedge sys_clk);
      #1 cs_n = 1'b1;
      io_in = ~io_in;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Bench for the suspend/resume and lock block; plays array engine
// and suspend decoder, host frames come from slk_host_model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
   fail_count++; $display("Error %s expected %0h seen %0h", n, e, s); \
   end end
module testbench;
   logic sys_clk = 1'b0, rstn = 1'b0, qpi_mode = 1'b0, suspend_req = 1'b0;
   logic protect_scheme_select = 1'b0, bp_region_protected = 1'b0;
   logic op_done = 1'b0, cs_n, sclk, write_latch_flag, in_progress_flag;
   logic erase_suspended_flag, program_suspended_flag, suspended_flag;
   logic reset_armed;
   logic [3:0] io_in, io_out, io_oe;
   logic [15:0] status_word;
   slk_pkg::slk_op_type op_cmd;
   int fail_count = 0, cmp_count = 0, starts = 0, resumes = 0;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (op_cmd.start === 1'b1) starts++;
      if (op_cmd.resume === 1'b1) resumes++;
   end
   slk_host_model i_host (.sys_clk, .qpi_mode, .io_out, .cs_n, .sclk,
      .io_in, .rd_byte());
   slk_suspend_lock i_dut (.sys_clk, .rstn, .cs_n, .sclk, .io_in, .io_out,
      .io_oe, .qpi_mode, .protect_scheme_select, .bp_region_protected,
      .suspend_req, .op_done, .op_cmd, .write_latch_flag, .in_progress_flag,
      .erase_suspended_flag, .program_suspended_flag, .suspended_flag,
      .reset_armed, .status_word);
   task automatic cmd(input logic [7:0] op, input logic [23:0] a = 24'h0,
                      input int nb = 1, input int xb = 0);
      i_host.frame({op, a, 8'h00}, nb, xb);
   endtask
   task automatic rdlock(input logic [23:0] a, input logic e);
      cmd(8'h3D, a, 5);
      `CHK("lock status", {7'h00, e}, i_host.rd_byte)
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge sys_clk) #1 s = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic t_lock;
      `CHK("status", 16'h0000, status_word)
      rdlock(24'h050000, 1'b1);
      cmd(8'h39, 24'h050000, 4);
      rdlock(24'h050000, 1'b1);
      cmd(8'h06);
      cmd(8'h39, 24'h050000, 4, 1);
      rdlock(24'h050000, 1'b1);
      `CHK("latch kept", 1'b1, write_latch_flag)
      cmd(8'h06);
      cmd(8'h39, 24'h05ABCD, 4);
      rdlock(24'h05FFFF, 1'b0);
      rdlock(24'h060000, 1'b1);
      cmd(8'h06);
      cmd(8'h36, 24'h05F000, 4);
      rdlock(24'h050000, 1'b1);
      cmd(8'h06);
      cmd(8'h39, 24'h001000, 4);
      rdlock(24'h001FFF, 1'b0);
      rdlock(24'h000000, 1'b1);
   endtask
   task automatic t_global;
      qpi_mode = 1'b1;
      cmd(8'h06);
      cmd(8'h98);
      rdlock(24'h3F0000, 1'b0);
      rdlock(24'h000000, 1'b0);
      cmd(8'h06);
      cmd(8'h7E);
      rdlock(24'h120000, 1'b1);
      qpi_mode = 1'b0;
   endtask
   task automatic t_protect;
      int s0;
      s0 = starts;
      protect_scheme_select = 1'b1;
      cmd(8'h06);
      cmd(8'hD8, 24'h030000, 4);
      `CHK("locked erase", s0, starts)
      `CHK("latch dropped", 1'b0, write_latch_flag)
      protect_scheme_select = 1'b0;
      bp_region_protected = 1'b1;
      cmd(8'h06);
      cmd(8'hD8, 24'h030000, 4);
      `CHK("range erase", s0, starts)
      bp_region_protected = 1'b0;
      cmd(8'h06);
      cmd(8'hD8, 24'h030000, 4);
      `CHK("open erase", s0 + 1, starts)
      pulse(op_done);
   endtask
   task automatic t_suspend;
      int s0;
      int r0;
      s0 = starts;
      r0 = resumes;
      cmd(8'h06);
      cmd(8'h20, 24'h011000, 4);
      pulse(suspend_req);
      `CHK("erase susp", 1'b1, status_word[15])
      cmd(8'h06);
      cmd(8'h02, 24'h011800, 5);
      `CHK("same sector", s0 + 1, starts)
      cmd(8'h06);
      cmd(8'h02, 24'h012000, 5);
      `CHK("nested start", s0 + 2, starts)
      `CHK("nested", 2'h3, {write_latch_flag, in_progress_flag})
      pulse(suspend_req);
      cmd(8'h7A);
      `CHK("no resume", r0, resumes)
      `CHK("nested held", 1'b1, in_progress_flag)
      pulse(op_done);
      `CHK("nested done", 3'h1, {write_latch_flag, in_progress_flag,
         erase_suspended_flag})
      cmd(8'h7A);
      `CHK("resume", r0 + 1, resumes)
      `CHK("resume target", {2'h1, 24'h011000}, {op_cmd.kind, op_cmd.addr})
      `CHK("resumed", 4'hC, {write_latch_flag, in_progress_flag,
         erase_suspended_flag, suspended_flag})
      pulse(op_done);
      `CHK("erase done", 1'b0, in_progress_flag)
   endtask
   task automatic t_prog_susp;
      cmd(8'h06);
      cmd(8'h02, 24'h020000, 5);
      pulse(suspend_req);
      `CHK("prog susp", 1'b1, status_word[10])
      cmd(8'h7A);
      repeat (20) @(posedge sys_clk);
      #1;
      pulse(suspend_req);
      `CHK("resuspend", 1'b1, program_suspended_flag)
      cmd(8'h7A);
      pulse(op_done);
      `CHK("idle", 16'h0000, status_word)
   endtask
   task automatic t_nop;
      cmd(8'h06);
      cmd(8'h66);
      `CHK("armed", 1'b1, reset_armed)
      cmd(8'h00);
      `CHK("nop", 2'h1, {reset_armed, write_latch_flag})
   endtask
   task automatic end_sim;
      $display("Compared %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 rstn = 1'b1;
      t_lock;
      t_global;
      t_protect;
      t_suspend;
      t_prog_susp;
      t_nop;
      end_sim;
   end
   // Hang guard well beyond the expected run length
   initial begin
      #1000000;
      fail_count++;
      end_sim;
   end
endmodule
`default_nettype wire
